//--- design/serial_flash_setting_cmd_decoder.sv
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Opcode 04 clears the write-permit latch, single-line or quad.
// - Opcode 05 shifts out the status register in both modes.
// - Opcode 15 shifts out the configuration register in both modes.
// - Opcode 01 with one data byte stores status when the write-permit latch is set; with two it also stores configuration.
// - Opcode C8 shifts out the extended address register in both modes.
// - Opcode C5 with exactly one data byte loads the extended address.
// - Opcode 68 selects individual block protection, single-line mode only.
// - Opcode 35, single-line only, enters quad command mode.
// - Opcode F5, quad only, returns to single-line command mode.
// - Opcode B7 enables four-byte addressing and sets its flag.
// - Opcode E9 disables four-byte addressing and clears its flag.
// - Opcodes 75 and B0 both suspend a running program or erase.
// - Opcodes 7A and 30 both resume a suspended program or erase.
// - Opcode B9 enters deep power-down in either mode.
// - Opcode AB leaves deep power-down in either mode.
// - Opcode C0 sets the burst length in either mode.
// - Opcode 41 enables factory mode in either mode.
// - Configuration bits 6 and 7 select the read dummy cycles.
module serial_flash_setting_cmd_decoder
    import flash_cmd_pkg::*;
(
    input wire logic i_ref_clk, // 250 MHz system clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_cs_n, // Link chip select, active low
    input wire logic i_sclk, // Link serial clock
    input wire logic [3:0] i_io_in, // Link data lines in
    output logic [3:0] o_io_out, // Link data lines out
    output logic [3:0] o_io_oe, // Link data line enables
    input wire logic [7:0] i_addr, // Register byte address
    input wire logic [31:0] i_wdata, // Register write data
    input wire logic i_wr, // Register write strobe
    input wire logic i_rd, // Register read strobe
    output logic [31:0] o_rdata, // Register read data
    output logic o_suspend_req, // Pulse: pause program/erase
    output logic o_resume_req, // Pulse: continue program/erase
    output logic o_wide_addr, // Four-byte addressing on
    output logic o_quad_mode, // Quad command mode on
    output logic o_deep_sleep, // Deep power-down on
    output logic o_protect_individual, // Individual block protection
    output logic o_factory_mode, // Factory mode on
    output logic [1:0] o_dummy_sel, // Read dummy-cycle select
    output logic [7:0] o_burst_len, // Burst length setting
    output logic [7:0] o_ext_addr // Extended address register
);
    // =====
    // Pin synchronisation and edge detection
    link_pins_t pins_raw;
    link_pins_t pins_s;
    link_pins_t pins_d_r;

    assign pins_raw = '{cs_n: i_cs_n, sclk: i_sclk, io: i_io_in};

    pin_sync #(
        .WIDTH($bits(link_pins_t))
    ) u_sync (
        .i_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_d_r <= '1;
        end else begin
            pins_d_r <= pins_s;
        end
    end

    wire frame = !pins_s.cs_n;
    wire cs_fall = pins_d_r.cs_n && !pins_s.cs_n;
    wire cs_rise = !pins_d_r.cs_n && pins_s.cs_n;
    wire sclk_rise = !pins_d_r.sclk && pins_s.sclk;
    wire sclk_fall = pins_d_r.sclk && !pins_s.sclk;

    // =====
    // State
    dec_state_t state_r;
    dec_state_t state_nxt;
    mode_flags_t flags_r;
    mode_flags_t flags_nxt;
    logic [1:0] ctrl_r;
    logic [7:0] sr_r;
    logic [7:0] cfg_r;
    logic [7:0] ear_r;
    logic [7:0] burst_r;
    logic [7:0] opc_r;
    logic [1:0] dcnt_r;
    logic [7:0] d0_r;
    logic [7:0] d1_r;
    logic [31:0] rdata_r;
    logic suspend_r;
    logic resume_r;

    wire link_en = ctrl_r[CTRL_LINK_EN_BIT];
    wire busy = ctrl_r[CTRL_BUSY_BIT];
    wire wip = busy && !flags_r.suspended;
    wire [7:0] status_view = {sr_r[7:2], flags_r.write_permit_latch, wip};

    // =====
    // Byte shifter
    logic [7:0] rx_byte;
    logic rx_valid;
    logic at_boundary;
    logic tx_load;
    logic [7:0] tx_byte;

    link_shifter u_shift (
        .i_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_frame(frame),
        .i_rise(sclk_rise),
        .i_fall(sclk_fall),
        .i_quad(flags_r.quad),
        .i_io(pins_s.io),
        .i_load(tx_load),
        .i_tx_byte(tx_byte),
        .i_tx_en(state_r == ST_READOUT),
        .o_rx_byte(rx_byte),
        .o_rx_valid(rx_valid),
        .o_at_boundary(at_boundary),
        .o_io_out(o_io_out),
        .o_io_oe(o_io_oe)
    );

    // =====
    // Opcode decode of the received first byte
    wire rx_spi_only = (rx_byte == OPC_PROTECT_SCHEME_SELECT) ||
        (rx_byte == OPC_QUAD_MODE_ENTRY);
    wire rx_quad_only = (rx_byte == OPC_QUAD_MODE_EXIT);
    wire rx_readout = (rx_byte == OPC_STATUS_READOUT) ||
        (rx_byte == OPC_CONFIG_READOUT) || (rx_byte == OPC_EXT_ADDR_READOUT);
    wire rx_both = rx_readout ||
        (rx_byte == OPC_SET_WRITE_PERMIT) || (rx_byte == OPC_CLEAR_WRITE_PERMIT) ||
        (rx_byte == OPC_FACTORY_MODE) || (rx_byte == OPC_STATUS_CONFIG_WRITE) ||
        (rx_byte == OPC_EXT_ADDR_LOAD) || (rx_byte == OPC_WIDE_ADDR_ENTRY) ||
        (rx_byte == OPC_WIDE_ADDR_EXIT) || (rx_byte == OPC_OP_PAUSE_A) ||
        (rx_byte == OPC_OP_PAUSE_B) || (rx_byte == OPC_OP_CONTINUE_A) ||
        (rx_byte == OPC_OP_CONTINUE_B) || (rx_byte == OPC_DEEP_SLEEP) ||
        (rx_byte == OPC_DEEP_SLEEP_WAKE) || (rx_byte == OPC_BURST_LENGTH);
    wire mode_ok = rx_both || (rx_spi_only && !flags_r.quad) ||
        (rx_quad_only && flags_r.quad);
    wire sleep_ok = !flags_r.sleep || (rx_byte == OPC_DEEP_SLEEP_WAKE);
    wire opc_take = rx_valid && (state_r == ST_OPCODE);
    wire opc_ok = opc_take && mode_ok && sleep_ok && link_en;

    // Readout byte, reloaded at each byte boundary
    wire [7:0] rd_opc = opc_take ? rx_byte : opc_r;
    assign tx_byte = (rd_opc == OPC_STATUS_READOUT) ? status_view :
        (rd_opc == OPC_CONFIG_READOUT) ? cfg_r : ear_r;
    assign tx_load = rx_valid && ((opc_ok && rx_readout) || (state_r == ST_READOUT));

    // =====
    // Command sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OPCODE: begin
                if (opc_ok) begin
                    state_nxt = rx_readout ? ST_READOUT : ST_COLLECT;
                end else if (opc_take) begin
                    state_nxt = ST_SKIP;
                end
            end
            ST_COLLECT, ST_READOUT, ST_SKIP: state_nxt = state_r;
        endcase
        if (cs_fall || cs_rise) begin
            state_nxt = ST_OPCODE;
        end
    end

    // =====
    // Execution at chip-select release
    wire is_status_config_write_cmd = (opc_r == OPC_STATUS_CONFIG_WRITE);
    wire one_byte_cmd = (opc_r == OPC_EXT_ADDR_LOAD) || (opc_r == OPC_BURST_LENGTH);
    wire [1:0] dmin = is_status_config_write_cmd ? STATUS_CONFIG_MIN_BYTES :
        one_byte_cmd ? ONE_DATA_BYTE : NO_DATA_BYTES;
    wire [1:0] dmax = is_status_config_write_cmd ? STATUS_CONFIG_MAX_BYTES :
        one_byte_cmd ? ONE_DATA_BYTE : NO_DATA_BYTES;
    wire exec = cs_rise && (state_r == ST_COLLECT) && at_boundary &&
        (dcnt_r >= dmin) && (dcnt_r <= dmax);

    wire ex_set_write_permit_cmd = exec && (opc_r == OPC_SET_WRITE_PERMIT);
    wire ex_clear_write_permit_cmd = exec && (opc_r == OPC_CLEAR_WRITE_PERMIT);
    wire ex_status_config_write_cmd = exec && is_status_config_write_cmd && flags_r.write_permit_latch;
    wire ex_ear = exec && (opc_r == OPC_EXT_ADDR_LOAD);
    wire ex_burst = exec && (opc_r == OPC_BURST_LENGTH);
    wire ex_pause = exec && ((opc_r == OPC_OP_PAUSE_A) || (opc_r == OPC_OP_PAUSE_B));
    wire ex_cont = exec && ((opc_r == OPC_OP_CONTINUE_A) || (opc_r == OPC_OP_CONTINUE_B));
    wire pause_go = ex_pause && busy && !flags_r.suspended;
    wire cont_go = ex_cont && flags_r.suspended;

    always_comb begin
        flags_nxt = flags_r;
        if (ex_set_write_permit_cmd) begin
            flags_nxt.write_permit_latch = 1'b1;
        end
        if (ex_clear_write_permit_cmd || ex_status_config_write_cmd) begin
            flags_nxt.write_permit_latch = 1'b0;
        end
        if (exec && (opc_r == OPC_PROTECT_SCHEME_SELECT)) begin
            flags_nxt.protect = 1'b1;
        end
        if (exec && (opc_r == OPC_QUAD_MODE_ENTRY)) begin
            flags_nxt.quad = 1'b1;
        end
        if (exec && (opc_r == OPC_QUAD_MODE_EXIT)) begin
            flags_nxt.quad = 1'b0;
        end
        if (exec && (opc_r == OPC_WIDE_ADDR_ENTRY)) begin
            flags_nxt.wide = 1'b1;
        end
        if (exec && (opc_r == OPC_WIDE_ADDR_EXIT)) begin
            flags_nxt.wide = 1'b0;
        end
        if (pause_go) begin
            flags_nxt.suspended = 1'b1;
        end
        if (cont_go || !busy) begin
            flags_nxt.suspended = 1'b0;
        end
        if (exec && (opc_r == OPC_DEEP_SLEEP)) begin
            flags_nxt.sleep = 1'b1;
        end
        if (exec && (opc_r == OPC_DEEP_SLEEP_WAKE)) begin
            flags_nxt.sleep = 1'b0;
        end
        if (exec && (opc_r == OPC_FACTORY_MODE)) begin
            flags_nxt.factory = 1'b1;
        end
    end

    // =====
    // Command capture
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_OPCODE;
            opc_r <= 8'h00;
            dcnt_r <= 2'h0;
            d0_r <= 8'h00;
            d1_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (cs_fall) begin
                dcnt_r <= 2'h0;
            end else if (opc_take) begin
                opc_r <= rx_byte;
            end else if (rx_valid && (state_r == ST_COLLECT)) begin
                dcnt_r <= (dcnt_r == 2'h3) ? dcnt_r : dcnt_r + 2'h1;
                d0_r <= (dcnt_r == 2'h0) ? rx_byte : d0_r;
                d1_r <= (dcnt_r == 2'h1) ? rx_byte : d1_r;
            end
        end
    end

    // =====
    // Device registers and mode flags
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_r <= FLAGS_RST;
            sr_r <= SR_RST;
            cfg_r <= CFG_RST;
            ear_r <= EXT_ADDR_RST;
            burst_r <= BURST_RST;
            suspend_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            suspend_r <= pause_go;
            resume_r <= cont_go;
            if (ex_status_config_write_cmd) begin
                sr_r <= {d0_r[7:2], 2'b00};
            end
            if (ex_status_config_write_cmd && (dcnt_r == STATUS_CONFIG_MAX_BYTES)) begin
                cfg_r <= d1_r;
            end
            if (ex_ear && (dcnt_r == ONE_DATA_BYTE)) begin
                ear_r <= d0_r;
            end
            if (ex_burst) begin
                burst_r <= d0_r;
            end
        end
    end

    // =====
    // Software register port
    wire [31:0] rd_mux =
        (i_addr == REG_CTRL) ? {30'h0, ctrl_r} :
        (i_addr == REG_STATUS) ? {24'h0, status_view} :
        (i_addr == REG_CONFIG) ? {24'h0, cfg_r} :
        (i_addr == REG_EXT_ADDR) ? {24'h0, ear_r} :
        (i_addr == REG_FLAGS) ? {25'h0, flags_r} :
        (i_addr == REG_BURST) ? {24'h0, burst_r} : 32'h0;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RST;
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= i_rd ? rd_mux : 32'h0;
            if (i_wr && (i_addr == REG_CTRL)) begin
                ctrl_r <= i_wdata[1:0];
            end
        end
    end

    // =====
    // Outputs
    assign o_rdata = rdata_r;
    assign o_suspend_req = suspend_r;
    assign o_resume_req = resume_r;
    assign o_wide_addr = flags_r.wide;
    assign o_quad_mode = flags_r.quad;
    assign o_deep_sleep = flags_r.sleep;
    assign o_protect_individual = flags_r.protect;
    assign o_factory_mode = flags_r.factory;
    assign o_dummy_sel = cfg_r[CFG_DUMMY_LSB+1:CFG_DUMMY_LSB];
    assign o_burst_len = burst_r;
    assign o_ext_addr = ear_r;
endmodule
`default_nettype wire

//--- design/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;
    // =====
    // Command opcodes
    localparam logic [7:0] OPC_SET_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OPC_CLEAR_WRITE_PERMIT = 8'h04;
    localparam logic [7:0] OPC_FACTORY_MODE = 8'h41;
    localparam logic [7:0] OPC_STATUS_READOUT = 8'h05;
    localparam logic [7:0] OPC_CONFIG_READOUT = 8'h15;
    localparam logic [7:0] OPC_STATUS_CONFIG_WRITE = 8'h01;
    localparam logic [7:0] OPC_EXT_ADDR_READOUT = 8'hC8;
    localparam logic [7:0] OPC_EXT_ADDR_LOAD = 8'hC5;
    localparam logic [7:0] OPC_PROTECT_SCHEME_SELECT = 8'h68;
    localparam logic [7:0] OPC_QUAD_MODE_ENTRY = 8'h35;
    localparam logic [7:0] OPC_QUAD_MODE_EXIT = 8'hF5;
    localparam logic [7:0] OPC_WIDE_ADDR_ENTRY = 8'hB7;
    localparam logic [7:0] OPC_WIDE_ADDR_EXIT = 8'hE9;
    localparam logic [7:0] OPC_OP_PAUSE_A = 8'h75;
    localparam logic [7:0] OPC_OP_PAUSE_B = 8'hB0;
    localparam logic [7:0] OPC_OP_CONTINUE_A = 8'h7A;
    localparam logic [7:0] OPC_OP_CONTINUE_B = 8'h30;
    localparam logic [7:0] OPC_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OPC_DEEP_SLEEP_WAKE = 8'hAB;
    localparam logic [7:0] OPC_BURST_LENGTH = 8'hC0;

    // =====
    // Data byte counts
    localparam logic [1:0] STATUS_CONFIG_MIN_BYTES = 2'h1;
    localparam logic [1:0] STATUS_CONFIG_MAX_BYTES = 2'h2;
    localparam logic [1:0] ONE_DATA_BYTE = 2'h1;
    localparam logic [1:0] NO_DATA_BYTES = 2'h0;

    // =====
    // Software register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_EXT_ADDR = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    localparam logic [7:0] REG_BURST = 8'h14;

    // =====
    // Field positions and reset values
    localparam int CFG_DUMMY_LSB = 6;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [7:0] SR_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] EXT_ADDR_RST = 8'h00;
    localparam logic [7:0] BURST_RST = 8'h00;

    // =====
    // Types
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } link_pins_t;

    typedef struct packed {
        logic suspended;
        logic factory;
        logic protect;
        logic sleep;
        logic quad;
        logic wide;
        logic write_permit_latch;
    } mode_flags_t;

    localparam mode_flags_t FLAGS_RST = 7'h00;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00,
        ST_COLLECT = 2'b01,
        ST_READOUT = 2'b11,
        ST_SKIP = 2'b10
    } dec_state_t;
endpackage
`default_nettype wire

//--- design/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 6
) (
    input wire logic i_clk, // Sampling clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] i_async, // Raw pins
    output logic [WIDTH-1:0] o_sync // Synchronised pins
);
    logic [WIDTH-1:0] meta_r;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync WIDTH must be at least 1");
        end
    endgenerate

    // =====
    // Two-stage synchroniser, first stage read only by second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            o_sync <= '1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- design/link_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module link_shifter (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_frame, // Chip select active
    input wire logic i_rise, // Link clock rising edge seen
    input wire logic i_fall, // Link clock falling edge seen
    input wire logic i_quad, // Four-line transfers
    input wire logic [3:0] i_io, // Synchronised data lines
    input wire logic i_load, // Load a byte for shifting out
    input wire logic [7:0] i_tx_byte, // Byte to shift out
    input wire logic i_tx_en, // Drive lines on falling edges
    output logic [7:0] o_rx_byte, // Last received byte
    output logic o_rx_valid, // One-cycle pulse per received byte
    output wire logic o_at_boundary, // No partial byte pending
    output logic [3:0] o_io_out, // Line output values
    output logic [3:0] o_io_oe // Line output enables
);
    logic [2:0] cnt_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    wire [3:0] step = i_quad ? 4'h4 : 4'h1;
    wire [3:0] cnt_sum = {1'b0, cnt_r} + step;
    wire [7:0] rx_nxt = i_quad ? {rx_r[3:0], i_io} : {rx_r[6:0], i_io[0]};
    wire take = i_frame && i_rise;
    wire shift = i_frame && i_fall && i_tx_en;

    assign o_at_boundary = (cnt_r == 3'h0);

    // =====
    // Receive path
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 3'h0;
            rx_r <= 8'h00;
            o_rx_byte <= 8'h00;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= take && cnt_sum[3];
            if (!i_frame) begin
                cnt_r <= 3'h0;
            end else if (take) begin
                cnt_r <= cnt_sum[2:0];
                rx_r <= rx_nxt;
                if (cnt_sum[3]) begin
                    o_rx_byte <= rx_nxt;
                end
            end
        end
    end

    // =====
    // Transmit path, MSB first, changes on falling edges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_r <= 8'h00;
            o_io_out <= 4'h0;
            o_io_oe <= 4'h0;
        end else if (i_load) begin
            tx_r <= i_tx_byte;
        end else if (!i_frame || !i_tx_en) begin
            o_io_oe <= 4'h0;
        end else if (shift) begin
            o_io_out <= i_quad ? tx_r[7:4] : {2'b00, tx_r[7], 1'b0};
            o_io_oe <= i_quad ? 4'hF : 4'h2;
            tx_r <= i_quad ? {tx_r[3:0], 4'h0} : {tx_r[6:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

//--- sim/flash_cmd_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_chk
    import flash_cmd_pkg::*;
(
    input wire logic i_ref_clk, // Clock
    input wire logic i_rst_n, // Reset
    input wire logic i_cs_n, // Select
    input wire logic [7:0] i_addr, // Address
    input wire logic i_rd, // Read strobe
    input wire logic [31:0] o_rdata, // Read data
    input wire logic [3:0] o_io_oe, // Line enables
    input wire logic o_suspend_req, // Pause pulse
    input wire logic o_resume_req, // Continue pulse
    input wire logic o_wide_addr, // Wide
    input wire logic o_quad_mode, // Quad
    input wire logic o_deep_sleep, // Sleep
    input wire logic o_protect_individual, // Protect
    input wire logic o_factory_mode, // Factory
    input wire logic [1:0] o_dummy_sel, // Dummy select
    input wire logic [7:0] o_burst_len, // Burst
    input wire logic [7:0] o_ext_addr // Ext address
);
    wire logic [4:0] mode_w = {o_factory_mode, o_protect_individual, o_deep_sleep,
        o_quad_mode, o_wide_addr};
    wire logic [20:0] state_w = {mode_w, o_ext_addr, o_burst_len};
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // =====
    // Register views
    chk_flags_view: assert property (i_rd && i_addr == REG_FLAGS |=>
        o_rdata[5:1] == $past(mode_w)) else $error("flags view differs");
    chk_burst_view: assert property (i_rd && i_addr == REG_BURST |=>
        o_rdata == {24'h0, $past(o_burst_len)}) else $error("burst view differs");
    chk_ext_view: assert property (i_rd && i_addr == REG_EXT_ADDR |=>
        o_rdata == {24'h0, $past(o_ext_addr)}) else $error("ext view differs");
    chk_dummy_view: assert property (i_rd && i_addr == REG_CONFIG |=>
        o_rdata[7:6] == $past(o_dummy_sel)) else $error("dummy select differs");
    // =====
    // Link behaviour
    chk_pause_pulse: assert property (o_suspend_req |=> !o_suspend_req)
        else $error("pause pulse too long");
    chk_resume_pulse: assert property (o_resume_req |=> !o_resume_req)
        else $error("continue pulse too long");
    chk_act_frame_end: assert property ($changed(state_w) |-> $past(i_cs_n, 2))
        else $error("setting changed inside a frame");
    chk_oe_shape: assert property (o_io_oe != 4'h0 |->
        o_io_oe == (o_quad_mode ? 4'hF : 4'h2)) else $error("bad enable pattern");
    chk_oe_release: assert property (i_cs_n [*5] |-> o_io_oe == 4'h0)
        else $error("lines driven while deselected");
    cover property (o_suspend_req);
    cover property ($rose(o_quad_mode));
    cover property (o_io_oe == 4'hF);
endmodule
bind serial_flash_setting_cmd_decoder flash_cmd_chk flash_cmd_chk_i (.i_ref_clk, .i_rst_n,
    .i_cs_n, .i_addr, .i_rd, .o_rdata, .o_io_oe, .o_suspend_req, .o_resume_req, .o_wide_addr,
    .o_quad_mode, .o_deep_sleep, .o_protect_individual, .o_factory_mode, .o_dummy_sel,
    .o_burst_len, .o_ext_addr);
`default_nettype wire

//--- sim/flash_host.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host (
    output logic o_cs_n, // Chip select
    output logic o_sclk, // Link clock
    output wire logic [3:0] o_io, // Resolved lines
    input wire logic [3:0] i_dev_io, // Device line values
    input wire logic [3:0] i_dev_oe // Device line enables
);
    logic [3:0] drv = 4'hA;
    initial o_cs_n = 1'b1;
    initial o_sclk = 1'b0;
    assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & drv);
    // =====
    // One frame: opcode first, MSB first, link clock idle low
    task automatic xfer(input logic q, input logic [23:0] d, input int nb, input bit rd,
        output logic [7:0] v);
        int w;
        w = q ? 4 : 1;
        v = 8'h00;
        o_cs_n = 1'b0;
        for (int i = 0; i < nb; i += w) begin
            drv = q ? d[23-i -: 4] : {drv[3:1], d[23-i]};
            #16 o_sclk = 1'b1;
            #16 o_sclk = 1'b0;
        end
        drv = ~drv;
        for (int i = 0; rd && i < 8; i += w) begin
            #16 o_sclk = 1'b1;
            #15 v = q ? {v[3:0], o_io} : {v[6:0], o_io[1]};
            #1 o_sclk = 1'b0;
        end
        #16 o_cs_n = 1'b1;
        #64;
    endtask
endmodule
`default_nettype wire

//--- sim/serial_flash_setting_cmd_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
module serial_flash_setting_cmd_decoder_bench;
    import flash_cmd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic cs_n, sclk, sus_p, res_p, wide, quad, sleep, prot, fact;
    logic busy = 1'b0;
    logic [3:0] io_in, io_out, io_oe;
    logic [1:0] dsel;
    logic [7:0] blen, eaddr, v, b1, b2;
    logic [7:0] sr = 8'h00, cfg = 8'h00, ea = 8'h00, bl = 8'h00;
    mode_flags_t ef = FLAGS_RST;
    int fail_count = 0, num_checks = 0, cyc = 0, n_sus = 0, n_res = 0;
    serial_flash_setting_cmd_decoder serial_flash_setting_cmd_decoder_i (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_io_in(io_in),
        .o_io_out(io_out), .o_io_oe(io_oe), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_suspend_req(sus_p), .o_resume_req(res_p),
        .o_wide_addr(wide), .o_quad_mode(quad), .o_deep_sleep(sleep),
        .o_protect_individual(prot), .o_factory_mode(fact), .o_dummy_sel(dsel),
        .o_burst_len(blen), .o_ext_addr(eaddr));
    flash_host flash_host_i (.o_cs_n(cs_n), .o_sclk(sclk), .o_io(io_in), .i_dev_io(io_out),
        .i_dev_oe(io_oe));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (sus_p === 1'b1) n_sus++;
        if (res_p === 1'b1) n_res++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    // =====
    // Expectations, bus and link helpers
    function automatic logic [31:0] status_view();
        return {24'h0, sr[7:2], ef.write_permit_latch, busy & ~ef.suspended};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic link(input logic [23:0] d, input int nb);
        @(posedge clk);
        #1 flash_host_i.xfer(ef.quad, d, nb, 1'b0, v);
    endtask
    task automatic rdout(input logic [7:0] op, input logic [7:0] e);
        @(posedge clk);
        #1 flash_host_i.xfer(ef.quad, {op, 16'h0}, 8, 1'b1, v);
        check({24'h0, v}, {24'h0, e});
    endtask
    task automatic verify();
        rreg(REG_FLAGS, {25'h0, ef});
        rreg(REG_STATUS, status_view());
        rreg(REG_CONFIG, {24'h0, cfg});
        check({16'h0, eaddr, blen}, {16'h0, ea, bl});
        check({27'h0, fact, prot, sleep, quad, wide},
            {27'h0, ef.factory, ef.protect, ef.sleep, ef.quad, ef.wide});
        check({30'h0, dsel}, {30'h0, cfg[7:6]});
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // =====
    // Main sequence
    initial begin
        void'($urandom(27));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rreg(REG_CTRL, 32'h1);
        rreg(8'h18, 32'h0);
        rreg(REG_EXT_ADDR, 32'h0);
        rreg(REG_BURST, 32'h0);
        verify();
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        link({OPC_SET_WRITE_PERMIT, 16'h0}, 8);
        ef.write_permit_latch = 1'b1;
        verify();
        rdout(OPC_STATUS_READOUT, status_view());
        link({OPC_STATUS_CONFIG_WRITE, b1, b2}, 24);
        {sr, cfg, ef.write_permit_latch} = {b1[7:2], 2'b00, b2, 1'b0};
        verify();
        rdout(OPC_CONFIG_READOUT, cfg);
        link({OPC_SET_WRITE_PERMIT, 16'h0}, 8);
        link({OPC_CLEAR_WRITE_PERMIT, 16'h0}, 8);
        link({OPC_STATUS_CONFIG_WRITE, ~b1, 8'h0}, 16);
        verify();
        link({OPC_SET_WRITE_PERMIT, 16'h0}, 9);
        verify();
        link({OPC_EXT_ADDR_LOAD, b2, 8'h0}, 16);
        link({OPC_EXT_ADDR_LOAD, b1, b1}, 24);
        link({OPC_BURST_LENGTH, b1, 8'h0}, 16);
        {ea, bl} = {b2, b1};
        verify();
        rdout(OPC_EXT_ADDR_READOUT, ea);
        link({OPC_WIDE_ADDR_ENTRY, 16'h0}, 8);
        link({OPC_FACTORY_MODE, 16'h0}, 8);
        link({OPC_QUAD_MODE_EXIT, 16'h0}, 8);
        {ef.wide, ef.factory} = 2'b11;
        verify();
        link({OPC_WIDE_ADDR_EXIT, 16'h0}, 8);
        link({OPC_DEEP_SLEEP, 16'h0}, 8);
        link({OPC_SET_WRITE_PERMIT, 16'h0}, 8);
        {ef.wide, ef.sleep} = 2'b01;
        verify();
        link({OPC_DEEP_SLEEP_WAKE, 16'h0}, 8);
        ef.sleep = 1'b0;
        wreg(REG_CTRL, 32'h3);
        busy = 1'b1;
        verify();
        for (int k = 0; k < 2; k++) begin
            link({k ? OPC_OP_PAUSE_B : OPC_OP_PAUSE_A, 16'h0}, 8);
            ef.suspended = 1'b1;
            verify();
            link({k ? OPC_OP_CONTINUE_B : OPC_OP_CONTINUE_A, 16'h0}, 8);
            ef.suspended = 1'b0;
            verify();
        end
        link({OPC_OP_CONTINUE_A, 16'h0}, 8);
        wreg(REG_CTRL, 32'h2);
        link({OPC_OP_PAUSE_A, 16'h0}, 8);
        check(n_sus, 32'h2);
        check(n_res, 32'h2);
        wreg(REG_CTRL, 32'h1);
        busy = 1'b0;
        link({OPC_QUAD_MODE_ENTRY, 16'h0}, 8);
        ef.quad = 1'b1;
        link({OPC_PROTECT_SCHEME_SELECT, 16'h0}, 8);
        link({OPC_SET_WRITE_PERMIT, 16'h0}, 8);
        link({OPC_EXT_ADDR_LOAD, b1, 8'h0}, 16);
        {ef.write_permit_latch, ea} = {1'b1, b1};
        verify();
        rdout(OPC_STATUS_READOUT, status_view());
        link({OPC_QUAD_MODE_EXIT, 16'h0}, 8);
        ef.quad = 1'b0;
        link({OPC_PROTECT_SCHEME_SELECT, 16'h0}, 8);
        ef.protect = 1'b1;
        verify();
        end_of_test();
    end
endmodule
`default_nettype wire
